/* File: src/sre_pkg.sv */
package sre_pkg;

  // --------------------------------------------------------------------------
  // register map and field layout
  // --------------------------------------------------------------------------
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 32;
  localparam logic [7:0] ADDR_CMD   = 8'h00;
  localparam logic [7:0] ADDR_DATA  = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_INFO  = 8'h0C;

  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_OP_W    = 5;
  localparam int CMD_BIT_LSB = 8;
  localparam int BIT_SEL_W   = 3;
  localparam int INFO_CNT_LSB = 16;

  // status flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  localparam logic [7:0]  DATA_RST  = 8'h00;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [7:0]  ZERO_BYTE = 8'h00;

  // --------------------------------------------------------------------------
  // instruction codes and bus carrier
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_LSR, OP_ROL, OP_ROR, OP_ASR, OP_BST, OP_BLD,
    OP_SEC, OP_CLC, OP_SEN, OP_CLN, OP_SES, OP_CLS, OP_SEV, OP_CLV,
    OP_SEH, OP_CLH, OP_SET, OP_CLT, OP_SLEEP, OP_WD_RESTART, OP_BREAK
  } sre_op_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } sre_apb_req_t;

endpackage

/* File: src/sre_exec.sv */
`timescale 1ns/10ps
module sre_exec (
  // clock, reset, enable
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  // apb slave
  input  wire sre_pkg::sre_apb_req_t apb_req,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // core side requests, status flags and result data
  output logic                     sleep_req,
  output logic                     watchdog_restart_instr,
  output logic                     break_req,
  output logic [7:0]               status_flag_register,
  output logic [7:0]               result_data
);
  import sre_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [7:0]           data_reg;
  logic [7:0]           flags_reg;
  logic [15:0]          cnt_reg;
  sre_op_t              last_op_reg;
  logic [31:0]          prdata_reg;
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic                 sleep_reg;
  logic                 wd_restart_reg;
  logic                 brk_reg;

  logic                 access_first;
  logic                 addr_ok;
  logic                 wr_done;
  logic                 exec_go;
  sre_op_t              cmd_op;
  logic [BIT_SEL_W-1:0] cmd_bit;
  logic [7:0]           res_next;
  logic [7:0]           flg_next;
  logic                 shift_c;
  logic                 is_shift;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  // one wait state lets read data come from a flop
  assign access_first = apb_req.psel & apb_req.penable & ~pready_reg;
  assign addr_ok      = (apb_req.paddr == ADDR_CMD) | (apb_req.paddr == ADDR_DATA) |
                        (apb_req.paddr == ADDR_FLAGS) | (apb_req.paddr == ADDR_INFO);
  assign wr_done      = clk_en & apb_req.psel & apb_req.penable & apb_req.pwrite &
                        pready_reg & ~pslverr_reg;
  assign exec_go      = wr_done & (apb_req.paddr == ADDR_CMD);
  assign cmd_op       = sre_op_t'(apb_req.pwdata[CMD_OP_LSB +: CMD_OP_W]);
  assign cmd_bit      = apb_req.pwdata[CMD_BIT_LSB +: BIT_SEL_W];

  // ready and error flops; pready drops after each completed transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      pready_reg  <= access_first;
      pslverr_reg <= access_first & ~addr_ok;
    end
  end

  // read data captured in the wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (clk_en && access_first) begin
      prdata_reg <= 32'h0000_0000;
      if (!apb_req.pwrite) begin
        case (apb_req.paddr)
          ADDR_CMD:   prdata_reg <= {27'h0, last_op_reg};
          ADDR_DATA:  prdata_reg <= {24'h000000, data_reg};
          ADDR_FLAGS: prdata_reg <= {24'h000000, flags_reg};
          ADDR_INFO:  prdata_reg <= {cnt_reg, 16'h0000};
          default:    prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // execution datapath
  // --------------------------------------------------------------------------
  // every instruction resolves in the single edge that accepts the command write
  always_comb begin
    res_next = data_reg;
    flg_next = flags_reg;
    shift_c  = 1'b0;
    is_shift = 1'b0;
    case (cmd_op)
      OP_LSR: begin
        res_next = {1'b0, data_reg[7:1]};
        shift_c  = data_reg[0];
        is_shift = 1'b1;
      end
      OP_ROL: begin
        res_next = {data_reg[6:0], flags_reg[FLG_C]};
        shift_c  = data_reg[7];
        is_shift = 1'b1;
      end
      OP_ROR: begin
        res_next = {flags_reg[FLG_C], data_reg[7:1]};
        shift_c  = data_reg[0];
        is_shift = 1'b1;
      end
      OP_ASR: begin
        res_next = {data_reg[7], data_reg[7:1]};
        shift_c  = data_reg[0];
        is_shift = 1'b1;
      end
      OP_BST:  flg_next[FLG_T] = data_reg[cmd_bit];
      OP_BLD:  res_next[cmd_bit] = flags_reg[FLG_T];
      OP_SEC:  flg_next[FLG_C] = 1'b1;
      OP_CLC:  flg_next[FLG_C] = 1'b0;
      OP_SEN:  flg_next[FLG_N] = 1'b1;
      OP_CLN:  flg_next[FLG_N] = 1'b0;
      OP_SES:  flg_next[FLG_S] = 1'b1;
      OP_CLS:  flg_next[FLG_S] = 1'b0;
      OP_SEV:  flg_next[FLG_V] = 1'b1;
      OP_CLV:  flg_next[FLG_V] = 1'b0;
      OP_SEH:  flg_next[FLG_H] = 1'b1;
      OP_CLH:  flg_next[FLG_H] = 1'b0;
      OP_SET:  flg_next[FLG_T] = 1'b1;
      OP_CLT:  flg_next[FLG_T] = 1'b0;
      // sleep, restart and break leave data and flags as they are
      default: ;
    endcase
    // shared flag logic for the four shift and rotate forms
    if (is_shift) begin
      flg_next[FLG_C] = shift_c;
      flg_next[FLG_Z] = (res_next == ZERO_BYTE);
      flg_next[FLG_N] = res_next[7];
      flg_next[FLG_V] = res_next[7] ^ shift_c;
    end
  end

  // data register: command result wins over a direct write, which cannot coincide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= DATA_RST;
    end else if (exec_go) begin
      data_reg <= res_next;
    end else if (wr_done && apb_req.paddr == ADDR_DATA) begin
      data_reg <= apb_req.pwdata[7:0];
    end
  end

  // status flags, software may also load them directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= FLAGS_RST;
    end else if (exec_go) begin
      flags_reg <= flg_next;
    end else if (wr_done && apb_req.paddr == ADDR_FLAGS) begin
      flags_reg <= apb_req.pwdata[7:0];
    end
  end

  // instruction bookkeeping visible to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_op_reg <= OP_NOP;
      cnt_reg     <= CNT_RST;
    end else if (exec_go) begin
      last_op_reg <= cmd_op;
      cnt_reg     <= cnt_reg + 16'h0001;
    end
  end

  // one-cycle requests to sleep control, watchdog and debug system
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg      <= 1'b0;
      wd_restart_reg <= 1'b0;
      brk_reg        <= 1'b0;
    end else if (clk_en) begin
      sleep_reg      <= exec_go & (cmd_op == OP_SLEEP);
      wd_restart_reg <= exec_go & (cmd_op == OP_WD_RESTART);
      brk_reg        <= exec_go & (cmd_op == OP_BREAK);
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign prdata                 = prdata_reg;
  assign pready                 = pready_reg;
  assign pslverr                = pslverr_reg;
  assign sleep_req              = sleep_reg;
  assign watchdog_restart_instr = wd_restart_reg;
  assign break_req              = brk_reg;
  assign status_flag_register   = flags_reg;
  assign result_data            = data_reg;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_issue(sre_op_t o);
    exec_go && cmd_op == o;
  endsequence

  sequence s_issue_any_force;
    exec_go && cmd_op inside {OP_SEC, OP_CLC, OP_SEN, OP_CLN, OP_SES, OP_CLS,
                              OP_SEV, OP_CLV, OP_SEH, OP_CLH, OP_SET, OP_CLT};
  endsequence

  a_lsr_result: assert property (
    s_issue(OP_LSR) |=> data_reg == {1'b0, $past(data_reg[7:1])} &&
                        flags_reg[FLG_C] == $past(data_reg[0]))
    else $error("logical shift right result or carry wrong");

  a_rol_carry: assert property (
    s_issue(OP_ROL) |=> data_reg == {$past(data_reg[6:0]), $past(flags_reg[FLG_C])} &&
                        flags_reg[FLG_C] == $past(data_reg[7]))
    else $error("rotate left through carry wrong");

  a_ror_carry: assert property (
    s_issue(OP_ROR) |=> data_reg == {$past(flags_reg[FLG_C]), $past(data_reg[7:1])} &&
                        flags_reg[FLG_C] == $past(data_reg[0]))
    else $error("rotate right through carry wrong");

  a_asr_sign: assert property (
    s_issue(OP_ASR) |=> data_reg[7] == $past(data_reg[7]) &&
                        data_reg[6:0] == $past(data_reg[7:1]))
    else $error("arithmetic shift right lost sign");

  a_bst_copy: assert property (
    s_issue(OP_BST) |=> flags_reg[FLG_T] == $past(data_reg[cmd_bit]) &&
                        flags_reg[5:0] == $past(flags_reg[5:0]) &&
                        flags_reg[FLG_I] == $past(flags_reg[FLG_I]))
    else $error("bit store did not copy into T alone");

  a_bld_bit: assert property (
    s_issue(OP_BLD) |=> data_reg[$past(cmd_bit)] == $past(flags_reg[FLG_T]) &&
                        $stable(flags_reg))
    else $error("bit load wrong or flags changed");

  a_flag_force_single: assert property (
    s_issue_any_force |=> $countones(flags_reg ^ $past(flags_reg)) <= 1 &&
                          $stable(data_reg))
    else $error("flag force touched more than one flag");

  a_sign_test_force: assert property (
    s_issue(OP_SES) |=> flags_reg[FLG_S] && $countones(flags_reg ^ $past(flags_reg)) <= 1)
    else $error("sign-test flag not set");

  a_overflow_clear: assert property (
    s_issue(OP_CLV) |=> !flags_reg[FLG_V])
    else $error("overflow flag not cleared");

  a_half_carry_set: assert property (
    s_issue(OP_SEH) |=> flags_reg[FLG_H])
    else $error("half-carry flag not set");

  a_t_flag_clear: assert property (
    s_issue(OP_CLT) |=> !flags_reg[FLG_T] && flags_reg[5:0] == $past(flags_reg[5:0]))
    else $error("T flag clear disturbed other flags");

  a_sleep_pulse: assert property (
    s_issue(OP_SLEEP) |=> sleep_req && $stable(flags_reg) ##1
                          (!$past(clk_en) || !sleep_req))
    else $error("sleep request not a single clean pulse");

  a_wd_restart_pulse: assert property (
    s_issue(OP_WD_RESTART) |=> watchdog_restart_instr && $stable(flags_reg))
    else $error("watchdog restart not signalled");

  a_break_no_flags: assert property (
    s_issue(OP_BREAK) |=> break_req && $stable(flags_reg) && $stable(data_reg))
    else $error("break altered state or gave no request");

  a_shift_overflow: assert property (
    exec_go && is_shift |=> flags_reg[FLG_V] == (flags_reg[FLG_N] ^ flags_reg[FLG_C]) &&
                           flags_reg[FLG_Z] == (data_reg == ZERO_BYTE) &&
                           flags_reg[FLG_N] == data_reg[7])
    else $error("shift flags Z N V inconsistent");

  // --------------------------------------------------------------------------
  // single-flag, request and bus checks
  // --------------------------------------------------------------------------
  a_carry_set: assert property (
    s_issue(OP_SEC) |=> flags_reg[FLG_C] && $stable(data_reg))
    else $error("carry flag not set");

  a_carry_clear: assert property (
    s_issue(OP_CLC) |=> !flags_reg[FLG_C])
    else $error("carry flag not cleared");

  a_neg_set: assert property (
    s_issue(OP_SEN) |=> flags_reg[FLG_N])
    else $error("negative flag not set");

  a_neg_clear: assert property (
    s_issue(OP_CLN) |=> !flags_reg[FLG_N])
    else $error("negative flag not cleared");

  a_sign_test_clear: assert property (
    s_issue(OP_CLS) |=> !flags_reg[FLG_S])
    else $error("sign-test flag not cleared");

  a_overflow_set: assert property (
    s_issue(OP_SEV) |=> flags_reg[FLG_V])
    else $error("overflow flag not set");

  a_half_carry_clear: assert property (
    s_issue(OP_CLH) |=> !flags_reg[FLG_H])
    else $error("half-carry flag not cleared");

  a_t_flag_set: assert property (
    s_issue(OP_SET) |=> flags_reg[FLG_T])
    else $error("T flag not set");

  a_sleep_keeps_data: assert property (
    s_issue(OP_SLEEP) |=> $stable(data_reg))
    else $error("sleep altered the data register");

  a_wd_restart_source: assert property (
    watchdog_restart_instr && $past(clk_en) |-> $past(exec_go && cmd_op == OP_WD_RESTART))
    else $error("watchdog restart without its command");

  a_break_source: assert property (
    break_req && $past(clk_en) |-> $past(exec_go && cmd_op == OP_BREAK))
    else $error("break request without its command");

  a_shift_upper_kept: assert property (
    exec_go && is_shift |=> flags_reg[FLG_I:FLG_S] == $past(flags_reg[FLG_I:FLG_S]))
    else $error("shift changed S H T or I");

  // a low enable must hold data, flags, command count and the bus handshake (pready)
  a_freeze_hold: assert property (
    !clk_en |=> $stable(data_reg) && $stable(flags_reg) && $stable(pready_reg) &&
                $stable(cnt_reg))
    else $error("state moved while clock enable low");

  a_ready_pulse: assert property (
    pready && clk_en |=> !pready)
    else $error("pready stood longer than one cycle");

  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("pslverr without pready");

endmodule

/* File: verification/sre_exec_tb.sv */
`timescale 1ns/10ps
module testbench;
  import sre_pkg::*;

  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  logic         pclk;
  logic         presetn;
  logic         clk_en;
  sre_apb_req_t req;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         sleep_req;
  logic         watchdog_restart_instr;
  logic         break_req;
  logic [7:0]   status_flag_register;
  logic [7:0]   result_data;
  int           n_errors;
  int           compares;
  int           n_cmds;
  logic [31:0]  rd;
  logic         err;
  logic [7:0]   ef;
  logic [7:0]   ed;
  logic [7:0]   dv [6] = '{8'h00, 8'h01, 8'h80, 8'hFF, 8'h5A, 8'hA5};
  int           fb [6] = '{FLG_C, FLG_N, FLG_S, FLG_V, FLG_H, FLG_T};

  sre_exec DUT (
    .pclk                   (pclk),
    .presetn                (presetn),
    .clk_en                 (clk_en),
    .apb_req                (req),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .sleep_req              (sleep_req),
    .watchdog_restart_instr (watchdog_restart_instr),
    .break_req              (break_req),
    .status_flag_register   (status_flag_register),
    .result_data            (result_data)
  );

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // --------------------------------------------------------------------------
  // reporting and compares
  // --------------------------------------------------------------------------
  task automatic test_done;
    $display("compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  // --------------------------------------------------------------------------
  // apb master: request held until pready is seen at a rising edge
  // --------------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic perr);
    int n;
    n = 0;
    @(posedge pclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= wd;
    @(posedge pclk);
    req.penable <= 1'b1;
    // pready is read before this edge's updates land, so no race
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("ERROR pready expected 1 seen 0");
    end
    rdat = prdata;
    perr = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic load(input logic [7:0] d, input logic [7:0] f);
    apb(1'b1, ADDR_DATA, {24'h000000, d}, rd, err);
    apb(1'b1, ADDR_FLAGS, {24'h000000, f}, rd, err);
  endtask

  // issue one command, then look at outputs in the cycle after execution
  task automatic run_op(input logic [4:0] o, input logic [2:0] b,
                        input logic [7:0] xd, input logic [7:0] xf);
    logic [2:0] xe;
    xe = {o == OP_SLEEP, o == OP_WD_RESTART, o == OP_BREAK};
    n_cmds++;
    apb(1'b1, ADDR_CMD, {21'h0, b, 3'h0, o}, rd, err);
    @(negedge pclk);
    cmp_word("result_data", 32'(xd), 32'(result_data));
    cmp_word("status_flag_register", 32'(xf), 32'(status_flag_register));
    cmp_word("event pulses", 32'(xe), 32'({sleep_req, watchdog_restart_instr, break_req}));
  endtask

  // returns {carry out, result} for the four shift codes
  function automatic logic [8:0] shift_model(input logic [4:0] o, input logic [7:0] d,
                                             input logic c);
    case (o)
      5'h01: return {d[0], 1'b0, d[7:1]};
      5'h02: return {d[7], d[6:0], c};
      5'h03: return {d[0], c, d[7:1]};
      default: return {d[0], d[7], d[7:1]};
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    presetn  = 1'b0;
    clk_en   = 1'b1;
    req      = '0;
    n_errors = 0;
    compares = 0;
    n_cmds   = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    cmp_word("reset flags", 32'h00000000, 32'(status_flag_register));
    cmp_word("reset data", 32'h00000000, 32'(result_data));
    // shifts and rotates with both carry inputs; upper flags must survive
    for (int o = 1; o <= 4; o++) begin
      for (int i = 0; i < 6; i++) begin
        for (int c = 0; c < 2; c++) begin
          ef = (c != 0) ? 8'h5F : 8'hAE;
          load(dv[i], ef);
          {ef[FLG_C], ed} = shift_model(5'(o), dv[i], ef[FLG_C]);
          ef[FLG_Z] = (ed == 8'h00);
          ef[FLG_N] = ed[7];
          ef[FLG_V] = ed[7] ^ ef[FLG_C];
          run_op(5'(o), 3'h0, ed, ef);
        end
      end
    end
    // bit store and bit load on every position, both flag values
    for (int b = 0; b < 8; b++) begin
      for (int t = 0; t < 2; t++) begin
        ed = 8'h96;
        ef = (t != 0) ? 8'hFF : 8'h00;
        load(ed, ef);
        ef[FLG_T] = ed[b];
        run_op(OP_BST, 3'(b), ed, ef);
        ef[FLG_T] = t[0];
        load(ed, ef);
        ed[b] = t[0];
        run_op(OP_BLD, 3'(b), ed, ef);
      end
    end
    // single-flag set and clear from all-zero and all-one starts
    for (int o = 7; o <= 18; o++) begin
      for (int s = 0; s < 2; s++) begin
        ef = (s != 0) ? 8'hFF : 8'h00;
        load(8'h3C, ef);
        ef[fb[(o - 7) / 2]] = o[0];
        run_op(5'(o), 3'h0, 8'h3C, ef);
      end
    end
    // a low clock enable in the wait state stretches the command, never loses it
    load(8'h81, 8'h00);
    fork
      run_op(OP_LSR, 3'h0, 8'h40, 8'h09);
      begin
        repeat (2) @(posedge pclk);
        clk_en <= 1'b0;
        repeat (3) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    // sleep, watchdog restart, break and an unused code: flags kept, one pulse each for the first three, none for the unused code
    for (int o = 19; o <= 22; o++) begin
      load(8'hC3, 8'hA5);
      run_op(5'(o), 3'h0, 8'hC3, 8'hA5);
      @(negedge pclk);
      cmp_word("pulses after", 32'h0, 32'({sleep_req, watchdog_restart_instr, break_req}));
    end
    // register read back and two unmapped places
    apb(1'b0, ADDR_DATA, 32'h0, rd, err);
    cmp_word("data read", 32'h000000C3, rd);
    cmp_bit("pslverr mapped", 1'b0, err);
    apb(1'b1, 8'h14, 32'h000000FF, rd, err);
    cmp_bit("pslverr write", 1'b1, err);
    apb(1'b0, 8'h10, 32'h0, rd, err);
    cmp_bit("pslverr read", 1'b1, err);
    cmp_word("unmapped read", 32'h00000000, rd);
    apb(1'b0, ADDR_FLAGS, 32'h0, rd, err);
    cmp_word("flags read", 32'h000000A5, rd);
    // last code issued was the unused one, and every command counts
    apb(1'b0, ADDR_CMD, 32'h0, rd, err);
    cmp_word("last op read", 32'h00000016, rd);
    apb(1'b0, ADDR_INFO, 32'h0, rd, err);
    cmp_word("command count read", {16'(n_cmds), 16'h0000}, rd);
    test_done();
  end

  // watchdog: the tests need well under 20000 cycles
  initial begin
    #400000;
    n_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    test_done();
  end
endmodule
